// ### core/intvec_pkg.sv
package intvec_pkg;

  // ----------------------------------------------------------------
  // Sources and vectors
  // ----------------------------------------------------------------
  localparam int          NUM_SRC      = 46;
  localparam logic [5:0]  VEC_OFFSET   = 6'h08;
  localparam logic [23:0] PRI_TBL_BASE = 24'h000014;
  localparam logic [23:0] ALT_TBL_BASE = 24'h000114;
  // Request numbers 15, 18 and 45 are reserved
  localparam logic [NUM_SRC-1:0] RSVD_MASK = 46'h2000_0004_8000;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses on APB)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_FLAG_LO = 8'h00;
  localparam logic [7:0] OFS_FLAG_HI = 8'h04;
  localparam logic [7:0] OFS_EN_LO   = 8'h08;
  localparam logic [7:0] OFS_EN_HI   = 8'h0c;
  localparam logic [7:0] OFS_STATUS  = 8'h10;
  localparam logic [7:0] OFS_CORE    = 8'h14;
  localparam logic [7:0] OFS_ICON1   = 8'h18;
  localparam logic [7:0] OFS_PRIO0   = 8'h20;
  localparam int         PRIO_WORDS  = 6;
  localparam int         PRIO_PER_WD = 8;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FLD_LEVEL_LSB = 5;
  localparam int FLD_EXT_BIT   = 3;
  localparam int FLD_NEST_DIS  = 15;
  localparam int FLD_ALT       = 0;
  localparam int FLAG_HI_W     = NUM_SRC - 32;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] PRIO_RST  = 3'h4;
  localparam logic [2:0] LEVEL_RST = 3'h0;

  // ----------------------------------------------------------------
  // Module state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_SRC-1:0]      flag;
    logic [NUM_SRC-1:0]      en;
    logic [NUM_SRC-1:0][2:0] prio;
    logic [2:0]              level;
    logic                    ext;
    logic                    nest_dis;
    logic                    alt;
    logic                    pready;
    logic                    pslverr;
    logic [31:0]             prdata;
    logic                    irq;
    logic                    vec_valid;
    logic [5:0]              vec_idx;
    logic [5:0]              vec_num;
    logic [2:0]              vec_prio;
    logic [23:0]             vec_addr;
  } state_s;

  localparam state_s STATE_RST = '{prio: {NUM_SRC{PRIO_RST}}, level: LEVEL_RST, default: '0};

endpackage

// ### core/intvec_arbiter.sv
`timescale 1ns/10ps
module intvec_arbiter
  import intvec_pkg::*;
#(
  parameter int N = NUM_SRC
) (
  input  wire logic [N-1:0]      pend,
  input  wire logic [N-1:0][2:0] prio,
  input  wire logic [3:0]        level,
  output logic                   valid,
  output logic [5:0]             idx,
  output logic [2:0]             best
);

  // ----------------------------------------------------------------
  // Highest priority wins, lowest number on a tie
  // ----------------------------------------------------------------
  always_comb begin
    valid = 1'b0;
    idx   = 6'h00;
    best  = 3'h0;
    for (int i = 0; i < N; i++) begin
      if (pend[i] && ({1'b0, prio[i]} > level)) begin
        if (!valid || (prio[i] > best)) begin
          valid = 1'b1;
          idx   = 6'(i);
          best  = prio[i];
        end
      end
    end
  end

endmodule

// ### core/interrupt_vector_priority.sv
`timescale 1ns/10ps
module interrupt_vector_priority
  import intvec_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  input  wire logic [NUM_SRC-1:0] irq_req,
  input  wire logic               cpu_ack,
  input  wire logic               ext_set,
  output logic                    irq,
  output logic                    vec_valid,
  output logic [5:0]              vec_num,
  output logic [2:0]              vec_prio,
  output logic [23:0]             vec_addr,
  output logic [3:0]              cpu_level
);

  // ----------------------------------------------------------------
  // State and arbiter
  // ----------------------------------------------------------------
  state_s     s_q;
  state_s     s_d;
  logic       arb_valid;
  logic [5:0] arb_idx;
  logic [2:0] arb_best;

  // Read value of one prio word
  function automatic logic [31:0] prio_word(input logic [NUM_SRC-1:0][2:0] p, input int w);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int k = 0; k < PRIO_PER_WD; k++) begin
      if (w * PRIO_PER_WD + k < NUM_SRC) begin
        r[4*k +: 3] = p[w * PRIO_PER_WD + k];
      end
    end
    return r;
  endfunction

  // Index of a prio word for an address, or -1
  function automatic int prio_sel(input logic [7:0] a);
    int r;
    r = -1;
    for (int w = 0; w < PRIO_WORDS; w++) begin
      if (a == OFS_PRIO0 + 8'(4 * w)) begin
        r = w;
      end
    end
    return r;
  endfunction

  // zero priority never beats a level
  intvec_arbiter #(
    .N (NUM_SRC)
  ) i_intvec_arbiter (
    .pend  (s_q.flag & s_q.en),
    .prio  (s_q.prio),
    .level ({s_q.ext, s_q.level}),
    .valid (arb_valid),
    .idx   (arb_idx),
    .best  (arb_best)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        acc;
    logic        wr;
    logic        hit;
    logic [31:0] rd;
    int          pw;
    acc = 1'b0;
    wr  = 1'b0;
    hit = 1'b0;
    rd  = 32'h0000_0000;
    pw  = -1;
    s_d = s_q;

    // APB: one wait state, write lands on the pready edge
    acc = psel & penable & s_q.pready;
    wr  = acc & pwrite;
    pw  = prio_sel(paddr);

    // Read mux and decode
    hit = 1'b1;
    unique case (paddr)
      OFS_FLAG_LO: rd = s_q.flag[31:0];
      OFS_FLAG_HI: rd = 32'(s_q.flag[NUM_SRC-1:32]);
      OFS_EN_LO:   rd = s_q.en[31:0];
      OFS_EN_HI:   rd = 32'(s_q.en[NUM_SRC-1:32]);
      // field at bits 7 to 5
      OFS_STATUS:  rd = 32'(s_q.level) << FLD_LEVEL_LSB;
      // extension bit shows level above seven
      OFS_CORE:    rd = 32'(s_q.ext) << FLD_EXT_BIT;
      OFS_ICON1:   rd = (32'(s_q.nest_dis) << FLD_NEST_DIS) | (32'(s_q.alt) << FLD_ALT);
      default: begin
        if (pw >= 0) begin
          rd = prio_word(s_q.prio, pw);
        end else begin
          hit = 1'b0;
        end
      end
    endcase

    s_d.pready  = psel & penable & ~s_q.pready;
    s_d.prdata  = (s_d.pready && !pwrite) ? rd : 32'h0000_0000;
    s_d.pslverr = s_d.pready & ~hit;

    // Enable and control writes
    if (wr) begin
      if (paddr == OFS_EN_LO) begin
        s_d.en[31:0] = pwdata;
      end
      if (paddr == OFS_EN_HI) begin
        s_d.en[NUM_SRC-1:32] = pwdata[FLAG_HI_W-1:0];
      end
      if (paddr == OFS_ICON1) begin
        s_d.nest_dis = pwdata[FLD_NEST_DIS];
        s_d.alt    = pwdata[FLD_ALT];
      end
      if (pw >= 0) begin
        for (int k = 0; k < PRIO_PER_WD; k++) begin
          if (pw * PRIO_PER_WD + k < NUM_SRC) begin
            s_d.prio[pw * PRIO_PER_WD + k] = pwdata[4*k +: 3];
          end
        end
      end
      if (paddr == OFS_STATUS && !s_q.nest_dis) begin
        s_d.level = pwdata[FLD_LEVEL_LSB +: 3];
      end
      if (paddr == OFS_CORE && !pwdata[FLD_EXT_BIT]) begin
        s_d.ext = 1'b0;
      end
    end

    // Flags: write one to clear
    if (wr && paddr == OFS_FLAG_LO) begin
      s_d.flag[31:0] = s_q.flag[31:0] & ~pwdata;
    end
    if (wr && paddr == OFS_FLAG_HI) begin
      s_d.flag[NUM_SRC-1:32] = s_q.flag[NUM_SRC-1:32] & ~pwdata[FLAG_HI_W-1:0];
    end

    // CPU accepts the presented vector and takes its level
    if (cpu_ack && s_q.vec_valid) begin
      s_d.flag[s_q.vec_idx] = 1'b0;
      s_d.level             = s_q.vec_prio;
    end

    s_d.flag = (s_d.flag | irq_req) & ~RSVD_MASK;

    // Hardware set of extension wins over software clear
    if (ext_set) begin
      s_d.ext = 1'b1;
    end

    // Level interrupt from unmasked sticky flags
    s_d.irq = |(s_d.flag & s_d.en);

    // blocking comes from the level compare
    s_d.vec_valid = arb_valid;
    s_d.vec_idx   = arb_idx;
    s_d.vec_prio  = arb_best;
    s_d.vec_num   = arb_idx + VEC_OFFSET;
    // table base plus two per number
    s_d.vec_addr  = (s_q.alt ? ALT_TBL_BASE : PRI_TBL_BASE) + {17'h0_0000, arb_idx, 1'b0};
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign pready    = s_q.pready;
  assign prdata    = s_q.prdata;
  assign pslverr   = s_q.pslverr;
  assign irq       = s_q.irq;
  assign vec_valid = s_q.vec_valid;
  assign vec_num   = s_q.vec_num;
  assign vec_prio  = s_q.vec_prio;
  assign vec_addr  = s_q.vec_addr;
  // effective level with extension on top
  assign cpu_level = {s_q.ext, s_q.level};

endmodule

// ### test/intvec_chk.sv
`timescale 1ns/10ps
module intvec_chk
  import intvec_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        ext_set,
  input wire logic        vec_valid,
  input wire logic [5:0]  vec_num,
  input wire logic [2:0]  vec_prio,
  input wire logic [23:0] vec_addr,
  input wire logic [3:0]  cpu_level
);
  // ----
  // Port checks
  // ----
  logic [23:0] ofs;
  // Table offset of the presented request
  assign ofs = {17'h0, vec_num - VEC_OFFSET, 1'b0};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; psel && !penable; endsequence
  sequence one_wait_s; !pready ##1 pready; endsequence
  chk_apb_wait: assert property (setup_s |=> one_wait_s)
    else $error("pready timing wrong");
  chk_vec_range: assert property (vec_valid |-> vec_num inside {[8:53]} && !(vec_num inside {23, 26, 53}))
    else $error("vector number out of range");
  chk_vec_addr: assert property (vec_valid |-> vec_addr == PRI_TBL_BASE + ofs || vec_addr == ALT_TBL_BASE + ofs)
    else $error("vector address wrong");
  chk_field_seven: assert property ((cpu_level[2:0] == 3'h7) [*2] |-> !vec_valid)
    else $error("vector at level seven");
  chk_ext_block: assert property (cpu_level[3] [*2] |-> !vec_valid)
    else $error("vector with extension set");
  chk_above_level: assert property (vec_valid && $stable(cpu_level) |-> {1'b0, vec_prio} > cpu_level)
    else $error("vector not above level");
  chk_ext_set: assert property (ext_set |=> cpu_level[3])
    else $error("extension bit not set");
  chk_ext_nosw: assert property (!cpu_level[3] && !ext_set |=> !cpu_level[3])
    else $error("extension bit set by software");
endmodule
bind interrupt_vector_priority intvec_chk i_intvec_chk (.*);

// ### test/cpu_model.sv
`timescale 1ns/10ps
module cpu_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ack_en,
  input  wire logic vec_valid,
  output logic      cpu_ack
);
  logic [1:0] hold_q;
  // One accept per vector, then skip the stale valid cycles
  // take supplied vector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_ack <= 1'b0;
      hold_q  <= 2'h0;
    end else begin
      cpu_ack <= ack_en && vec_valid && !cpu_ack && hold_q == 2'h0;
      hold_q  <= {hold_q[0], cpu_ack};
    end
  end
endmodule

// ### test/testbench.sv
`timescale 1ns/10ps
module testbench
  import intvec_pkg::*;
;
  logic               pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic               pwrite = 1'b0, ext_set = 1'b0, ack_en = 1'b0, err;
  logic               pready, pslverr, irq, vec_valid, cpu_ack;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0, prdata, rd;
  logic [NUM_SRC-1:0] irq_req = '0;
  logic [5:0]         vec_num;
  logic [2:0]         vec_prio;
  logic [23:0]        vec_addr;
  logic [3:0]         cpu_level;
  int                 errors = 0, samples_checked = 0;
  int                 srcs [5] = '{0, 3, 31, 32, 44};

  interrupt_vector_priority i_interrupt_vector_priority (
    .pclk      (pclk),
    .presetn   (presetn),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .pready    (pready),
    .prdata    (prdata),
    .pslverr   (pslverr),
    .irq_req   (irq_req),
    .cpu_ack   (cpu_ack),
    .ext_set   (ext_set),
    .irq       (irq),
    .vec_valid (vec_valid),
    .vec_num   (vec_num),
    .vec_prio  (vec_prio),
    .vec_addr  (vec_addr),
    .cpu_level (cpu_level)
  );
  cpu_model i_cpu_model (
    .pclk      (pclk),
    .presetn   (presetn),
    .ack_en    (ack_en),
    .vec_valid (vec_valid),
    .cpu_ack   (cpu_ack)
  );
  // Clock at 100 MHz
  always #5 pclk = ~pclk;

  task report_and_stop;
    if (errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task limit(input int n);
    if (n >= 20) begin
      errors++;
      report_and_stop();
    end
  endtask
  // Setup, access until pready, then one idle edge before the next setup
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    limit(n);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check("prdata", rd, exp);
  endtask
  task wait_vec(input logic want);
    int n;
    n = 0;
    while (vec_valid !== want && n < 20) begin
      @(posedge pclk);
      n++;
    end
    limit(n);
  endtask
  task pulse(input logic [NUM_SRC-1:0] m);
    irq_req <= m;
    @(posedge pclk);
    irq_req <= '0;
  endtask
  task settle;
    repeat (3) @(posedge pclk);
  endtask

  task t_reset;
    check("cpu_level", cpu_level, 0);
    rdc(OFS_STATUS, 32'h0);
    rdc(OFS_CORE, 32'h0);
    rdc(OFS_PRIO0, 32'h4444_4444);
    apb(1'b0, 8'h40, 32'h0);
    check("pslverr", err, 1);
    check("prdata", rd, 0);
  endtask
  // Sources 0, 3, 31, 32 and 44 in turn through both tables, acknowledged by the CPU model
  task t_vectors;
    apb(1'b1, OFS_EN_LO, 32'hffff_ffff);
    apb(1'b1, OFS_EN_HI, 32'h3fff);
    ack_en <= 1'b1;
    pulse(46'h2000_0004_8000);
    settle();
    check("irq", irq, 0);
    for (int alt = 0; alt < 2; alt++) begin
      apb(1'b1, OFS_ICON1, alt);
      foreach (srcs[i]) begin
        pulse(46'h1 << srcs[i]);
        wait_vec(1'b1);
        check("vec_num", vec_num, srcs[i] + 8);
        check("vec_addr", vec_addr, (alt ? 24'h000114 : 24'h000014) + 2 * srcs[i]);
        wait_vec(1'b0);
        rdc(OFS_STATUS, 32'h80);
        apb(1'b1, OFS_STATUS, 32'h0);
      end
    end
    ack_en <= 1'b0;
  endtask
  // Sources 5 and 9 pending; priorities, levels and masking
  task t_levels;
    pulse(46'h220);
    wait_vec(1'b1);
    check("vec_num", vec_num, 13);
    check("irq", irq, 1);
    apb(1'b1, OFS_PRIO0 + 8'h04, 32'h4444_4464);
    settle();
    check("vec_num", vec_num, 17);
    check("vec_prio", vec_prio, 6);
    // Both pending sources at priority zero are never presented
    apb(1'b1, OFS_PRIO0, 32'h4404_4444);
    apb(1'b1, OFS_PRIO0 + 8'h04, 32'h4444_4404);
    settle();
    check("vec_valid", vec_valid, 0);
    apb(1'b1, OFS_PRIO0, 32'h4444_4444);
    apb(1'b1, OFS_PRIO0 + 8'h04, 32'h4444_4464);
    apb(1'b1, OFS_STATUS, 32'hc0);
    settle();
    check("vec_valid", vec_valid, 0);
    apb(1'b1, OFS_STATUS, 32'h60);
    rdc(OFS_STATUS, 32'h60);
    settle();
    check("vec_valid", vec_valid, 1);
    ext_set <= 1'b1;
    @(posedge pclk);
    ext_set <= 1'b0;
    settle();
    check("cpu_level", cpu_level, 4'hb);
    check("vec_valid", vec_valid, 0);
    apb(1'b1, OFS_CORE, 32'h0);
    apb(1'b1, OFS_CORE, 32'h8);
    rdc(OFS_CORE, 32'h0);
    apb(1'b1, OFS_STATUS, 32'he0);
    settle();
    check("vec_valid", vec_valid, 0);
    apb(1'b1, OFS_ICON1, 32'h8000);
    apb(1'b1, OFS_STATUS, 32'h0);
    rdc(OFS_STATUS, 32'he0);
    apb(1'b1, OFS_EN_LO, 32'h0);
    settle();
    check("irq", irq, 0);
    apb(1'b1, OFS_EN_LO, 32'hffff_ffff);
    apb(1'b1, OFS_FLAG_LO, 32'h220);
    settle();
    check("irq", irq, 0);
  endtask

  // Reset for two cycles, then the scenarios
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_vectors();
    t_levels();
    report_and_stop();
  end
endmodule
